// >>> rtl/flash_read_pkg.sv
// constants and types shared by the flash read device and host ends
package flash_read_pkg;
	localparam logic [7:0] OP_FAST_READ  = 8'h0B;
	localparam logic [7:0] OP_DUAL_IO    = 8'hBB;
	localparam logic [7:0] OP_DUAL_OUT   = 8'h3B;
	localparam logic [7:0] OP_QUAD_OUT   = 8'h6B;
	localparam logic [3:0] MODE_CONT     = 4'hA;
	localparam logic [7:0] MODE_EXIT     = 8'hFF;
	localparam int         ADDR_BITS     = 24;
	localparam int         DUMMY_CLOCKS  = 8;
	localparam int         MAX_SCK_KHZ   = 104000;
	localparam int         SYS_CLK_KHZ   = 200000;
	// fastest legal host divider: half periods of system clock, rounded up
	localparam int         MIN_HALF_DIV  = (SYS_CLK_KHZ + 2 * MAX_SCK_KHZ - 1) / (2 * MAX_SCK_KHZ);
	localparam logic [23:0] ADDR_ZERO    = 24'h000000;

	// read command kinds
	typedef enum logic [2:0] {
		CMD_SINGLE = 3'h0,
		CMD_DUAL_IO = 3'h1,
		CMD_DUAL_OUT = 3'h2,
		CMD_QUAD_OUT = 3'h3,
		CMD_NONE = 3'h4
	} read_cmd_t;

	// lines carried per clock for a data phase
	function automatic logic [2:0] data_width(input read_cmd_t c);
		case (c)
			CMD_DUAL_IO, CMD_DUAL_OUT: data_width = 3'h2;
			CMD_QUAD_OUT:              data_width = 3'h4;
			default:                   data_width = 3'h1;
		endcase
	endfunction
endpackage

// >>> rtl/flash_link_if.sv
// interface joining the flash device end and the host end
`timescale 1ns/1ps
`default_nettype none
interface flash_link_if;
	logic       sck;
	logic       select_n;
	logic       pause_n;
	logic [3:0] host_dq_o;
	logic [3:0] host_dq_oe;
	logic [3:0] dev_dq_o;
	logic [3:0] dev_dq_oe;
	logic [3:0] dq;

	// wired level of the data lines, pulled high when nobody drives
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			if (dev_dq_oe[i])
				dq[i] = dev_dq_o[i];
			else if (host_dq_oe[i])
				dq[i] = host_dq_o[i];
			else
				dq[i] = 1'b1;
		end
	end

	modport device (input sck, input select_n, input pause_n, input dq,
		output dev_dq_o, output dev_dq_oe);
	modport host (output sck, output select_n, output pause_n, input dq,
		output host_dq_o, output host_dq_oe);
endinterface
`default_nettype wire

// >>> rtl/pin_sync.sv
// two flip-flop synchroniser for a bundle of pins
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	input  wire logic             clk_sys_i,
	input  wire logic             reset_n_i,
	input  wire logic [WIDTH-1:0] pin_i,
	output logic      [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta_reg;

	// first stage only feeds the second
	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			meta_reg <= INIT;
			sync_o   <= INIT;
		end else begin
			meta_reg <= pin_i;
			sync_o   <= meta_reg;
		end
	end
endmodule
`default_nettype wire

// >>> rtl/flash_read_device.sv
// device end: read command decoder and data shifter of the serial flash
`timescale 1ns/1ps
`default_nettype none
module flash_read_device #(
	parameter int ARRAY_ADDR_BITS = 8
) (
	input  wire logic                       clk_sys_i,
	input  wire logic                       reset_n_i,
	flash_link_if.device                    link,
	input  wire logic                       write_in_progress_i,
	output logic      [ARRAY_ADDR_BITS-1:0] mem_addr_o,
	input  wire logic [7:0]                 mem_data_i,
	output logic                            busy_o,
	output logic                            continuous_read_mode_o
);
	initial begin
		if (ARRAY_ADDR_BITS < 1 || ARRAY_ADDR_BITS > flash_read_pkg::ADDR_BITS)
			$error("array address width out of range");
	end

	typedef enum logic [5:0] {
		ST_IDLE  = 6'b000001,
		ST_OP    = 6'b000010,
		ST_ADDR  = 6'b000100,
		ST_DUMMY = 6'b001000,
		ST_DATA  = 6'b010000,
		ST_SKIP  = 6'b100000
	} dev_state_t;

	typedef struct packed {
		dev_state_t                  st;
		flash_read_pkg::read_cmd_t   cmd;
		logic [7:0]                  cnt;
		logic [31:0]                 shin;
		logic [7:0]                  shout;
		logic [3:0]                  bits_left;
		logic [ARRAY_ADDR_BITS-1:0]  addr;
		logic                        cont;
		logic                        sck_prev;
		logic                        drive;
		logic [3:0]                  dq_out;
		logic [3:0]                  dq_oe;
	} dev_t;

	dev_t s_reg;
	dev_t s_next;
	logic       sck_s;
	logic       sel_n_s;
	logic       pause_n_s;
	logic [3:0] dq_s;
	logic       rise;
	logic       fall;
	logic [2:0] w;
	logic [3:0] nbits;

	// pins cross into the system clock
	pin_sync #(.WIDTH(7), .INIT(7'h3F)) u_sync ( // idle: clock low, select and pause high
		.clk_sys_i (clk_sys_i),
		.reset_n_i (reset_n_i),
		.pin_i     ({link.sck, link.select_n, link.pause_n, link.dq}),
		.sync_o    ({sck_s, sel_n_s, pause_n_s, dq_s})
	);

	// edges of the link clock; paused device sees none
	assign rise = sck_s & ~s_reg.sck_prev & pause_n_s;
	assign fall = ~sck_s & s_reg.sck_prev & pause_n_s;
	assign w    = flash_read_pkg::data_width(s_reg.cmd);

	always_comb begin
		s_next = s_reg;
		s_next.sck_prev = sck_s;
		nbits = 4'h0;
		if (sel_n_s) begin
			// deselect ends any sequence
			s_next.st     = ST_IDLE;
			s_next.drive  = 1'b0;
			s_next.cnt    = 8'h00;
			s_next.cmd    = s_reg.cont ? flash_read_pkg::CMD_DUAL_IO
				: flash_read_pkg::CMD_NONE;
		end else begin
			case (s_reg.st)
				ST_IDLE: begin
					s_next.cnt = 8'h00;
					if (write_in_progress_i)
						s_next.st = ST_SKIP;
					else if (s_reg.cont)
						s_next.st = ST_ADDR;
					else
						s_next.st = ST_OP;
				end
				ST_OP: begin
					if (rise) begin
						s_next.shin = {s_reg.shin[30:0], dq_s[0]};
						s_next.cnt  = s_reg.cnt + 8'h01;
						if (s_reg.cnt == 8'h07) begin
							s_next.cnt = 8'h00;
							s_next.st  = ST_ADDR;
							case ({s_reg.shin[6:0], dq_s[0]})
								flash_read_pkg::OP_FAST_READ: s_next.cmd = flash_read_pkg::CMD_SINGLE;
								flash_read_pkg::OP_DUAL_IO:   s_next.cmd = flash_read_pkg::CMD_DUAL_IO;
								flash_read_pkg::OP_DUAL_OUT:  s_next.cmd = flash_read_pkg::CMD_DUAL_OUT;
								flash_read_pkg::OP_QUAD_OUT:  s_next.cmd = flash_read_pkg::CMD_QUAD_OUT;
								default:                      s_next.st  = ST_SKIP;
							endcase
						end
					end
				end
				ST_ADDR: begin
					if (rise) begin
						if (s_reg.cmd == flash_read_pkg::CMD_DUAL_IO) begin
							// address and mode, two bits, msb on line 1
							s_next.shin = {s_reg.shin[29:0], dq_s[1], dq_s[0]};
							s_next.cnt  = s_reg.cnt + 8'h02;
						end else begin
							s_next.shin = {s_reg.shin[30:0], dq_s[0]};
							s_next.cnt  = s_reg.cnt + 8'h01;
						end
						if (s_next.cnt == 8'd32 && s_reg.cmd == flash_read_pkg::CMD_DUAL_IO) begin
							s_next.addr = s_next.shin[8 +: ARRAY_ADDR_BITS];
							s_next.cont = (s_next.shin[7:4] == flash_read_pkg::MODE_CONT);
							s_next.st   = ST_DATA;
							s_next.bits_left = 4'h0;
						end else if (s_next.cnt == 8'(flash_read_pkg::ADDR_BITS)
							&& s_reg.cmd != flash_read_pkg::CMD_DUAL_IO) begin
							s_next.addr = s_next.shin[0 +: ARRAY_ADDR_BITS];
							s_next.cnt  = 8'h00;
							s_next.st   = ST_DUMMY;
						end
					end
				end
				ST_DUMMY: begin
					if (rise) begin
						s_next.cnt = s_reg.cnt + 8'h01;
						if (s_reg.cnt == 8'(flash_read_pkg::DUMMY_CLOCKS - 1)) begin
							s_next.st = ST_DATA;
							s_next.bits_left = 4'h0;
						end
					end
				end
				ST_DATA: begin
					if (fall) begin
						nbits = {1'b0, w};
						s_next.drive = 1'b1;
						if (s_reg.bits_left == 4'h0) begin
							// load next byte and bump address with wrap
							s_next.shout = mem_data_i << w;
							s_next.addr  = s_reg.addr + 1'b1;
							s_next.bits_left = 4'h8 - nbits;
							s_next.dq_out = 4'h0;
							case (w)
								3'h4: s_next.dq_out = mem_data_i[7:4];
								3'h2: s_next.dq_out = {2'b00, mem_data_i[7:6]};
								default: s_next.dq_out = {2'b00, mem_data_i[7], 1'b0};
							endcase
						end else begin
							s_next.shout = s_reg.shout << w;
							s_next.bits_left = s_reg.bits_left - nbits;
							case (w)
								3'h4: s_next.dq_out = s_reg.shout[7:4];
								3'h2: s_next.dq_out = {2'b00, s_reg.shout[7:6]};
								default: s_next.dq_out = {2'b00, s_reg.shout[7], 1'b0};
							endcase
						end
					end
				end
				ST_SKIP: s_next.st = ST_SKIP;
				default: s_next.st = ST_IDLE;
			endcase
		end
		// output enables follow command width; pause floats all
		case (w)
			3'h4:    s_next.dq_oe = 4'hF;
			3'h2:    s_next.dq_oe = 4'h3;
			default: s_next.dq_oe = 4'h2; // single output rides on line 1
		endcase
		if (!s_next.drive || !pause_n_s)
			s_next.dq_oe = 4'h0;
		// single output bit is placed on line 1 where it is shifted
	end

	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			s_reg.st        <= ST_IDLE;
			s_reg.cmd       <= flash_read_pkg::CMD_NONE;
			s_reg.cnt       <= 8'h00;
			s_reg.shin      <= 32'h00000000;
			s_reg.shout     <= 8'h00;
			s_reg.bits_left <= 4'h0;
			s_reg.addr      <= '0;
			s_reg.cont      <= 1'b0;
			s_reg.sck_prev  <= 1'b0;
			s_reg.drive     <= 1'b0;
			s_reg.dq_out    <= 4'h0;
			s_reg.dq_oe     <= 4'h0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign link.dev_dq_o       = s_reg.dq_out;
	assign link.dev_dq_oe      = s_reg.dq_oe;
	assign mem_addr_o          = s_reg.addr;
	assign busy_o              = ~s_reg.st[0];
	assign continuous_read_mode_o = s_reg.cont;
endmodule
`default_nettype wire

// >>> rtl/flash_read_host.sv
// host end: issues fast read commands and collects data bytes
`timescale 1ns/1ps
`default_nettype none
module flash_read_host #(
	parameter int HALF_DIV = 2
) (
	input  wire logic        clk_sys_i,
	input  wire logic        reset_n_i,
	flash_link_if.host       link,
	input  wire logic        start_i,
	input  wire logic [2:0]  cmd_i,
	input  wire logic [23:0] addr_i,
	input  wire logic        keep_cont_i,
	input  wire logic        skip_opcode_i,
	input  wire logic        stop_i,
	input  wire logic        pause_i,
	output logic             ready_o,
	output logic [7:0]       data_o,
	output logic             data_valid_o
);
	initial begin
		if (HALF_DIV < flash_read_pkg::MIN_HALF_DIV || HALF_DIV > 255)
			$error("link clock divider too fast or too large");
	end

	typedef enum logic [2:0] {
		H_IDLE = 3'b001,
		H_RUN  = 3'b010,
		H_END  = 3'b100
	} host_state_t;

	typedef struct packed {
		host_state_t st;
		logic [7:0]  div;
		logic        sck;
		logic        sel_n;
		logic        pause_n;
		logic [2:0]  cmd;
		logic [47:0] tx;
		logic [7:0]  clocks;
		logic [7:0]  rx;
		logic [3:0]  rx_bits;
		logic [7:0]  data;
		logic        valid;
		logic [3:0]  dq_out;
		logic [3:0]  dq_oe;
	} host_t;

	host_t h_reg;
	host_t h_next;
	logic [3:0] dq_s;
	logic [7:0] pre_clocks;
	logic [2:0] w;
	logic [7:0] mode_byte;

	pin_sync #(.WIDTH(4), .INIT(4'hF)) u_sync (
		.clk_sys_i (clk_sys_i),
		.reset_n_i (reset_n_i),
		.pin_i     (link.dq),
		.sync_o    (dq_s)
	);

	assign w = flash_read_pkg::data_width(flash_read_pkg::read_cmd_t'(h_reg.cmd));
	// mode byte: upper nibble A keeps continuous read, FF leaves it
	assign mode_byte = keep_cont_i ? {flash_read_pkg::MODE_CONT, 4'h0}
		: flash_read_pkg::MODE_EXIT;
	// clocks before data: opcode, address (and mode or dummy)
	assign pre_clocks = (h_reg.cmd == flash_read_pkg::CMD_DUAL_IO)
		? (h_reg.tx[47] ? 8'd16 : 8'd24) : 8'd40;

	always_comb begin
		h_next = h_reg;
		h_next.valid = 1'b0;
		case (h_reg.st)
			H_IDLE: begin
				h_next.sck = 1'b0;
				h_next.sel_n = 1'b1;
				h_next.pause_n = 1'b1;
				h_next.dq_oe = 4'h0;
				if (start_i) begin
					h_next.st = H_RUN;
					h_next.sel_n = 1'b0;
					h_next.cmd = cmd_i;
					h_next.clocks = 8'h00;
					h_next.rx_bits = 4'h0;
					h_next.div = 8'h00;
					case (cmd_i)
						3'(flash_read_pkg::CMD_DUAL_IO):
							// skip flag rides in tx msb; next bit to send sits at bit 39
							h_next.tx = skip_opcode_i
								? {1'b1, 7'h00, addr_i, mode_byte, 8'h00}
								: {1'b0, 7'h00, flash_read_pkg::OP_DUAL_IO, addr_i, mode_byte};
						3'(flash_read_pkg::CMD_DUAL_OUT):
							h_next.tx = {8'h00, flash_read_pkg::OP_DUAL_OUT, addr_i, 8'h00};
						3'(flash_read_pkg::CMD_QUAD_OUT):
							h_next.tx = {8'h00, flash_read_pkg::OP_QUAD_OUT, addr_i, 8'h00};
						default:
							h_next.tx = {8'h00, flash_read_pkg::OP_FAST_READ, addr_i, 8'h00};
					endcase
					// first bits must stand before the first rising edge
					if (cmd_i == 3'(flash_read_pkg::CMD_DUAL_IO) && skip_opcode_i) begin
						h_next.dq_out = {2'b00, h_next.tx[39:38]};
						h_next.dq_oe  = 4'h3;
						h_next.tx     = {h_next.tx[47:40], h_next.tx[37:0], 2'b00};
					end else begin
						h_next.dq_out = {3'b000, h_next.tx[39]};
						h_next.dq_oe  = 4'h1;
						h_next.tx     = {h_next.tx[47:40], h_next.tx[38:0], 1'b0};
					end
				end
			end
			H_RUN: begin
				// pause changes only while the link clock is low
				if (!h_reg.sck)
					h_next.pause_n = ~pause_i;
				if (h_reg.pause_n && !(pause_i && !h_reg.sck))
					h_next.div = h_reg.div + 8'h01;
				// no clock edge while a pause is held or being entered
				if (h_reg.div == 8'(HALF_DIV - 1) && h_reg.pause_n
					&& !(pause_i && !h_reg.sck)) begin
					h_next.div = 8'h00;
					h_next.sck = ~h_reg.sck;
					if (!h_reg.sck) begin
						// rising edge: capture data phase lines
						if (h_reg.clocks >= pre_clocks) begin
							case (w)
								3'h4: h_next.rx = {h_reg.rx[3:0], dq_s};
								3'h2: h_next.rx = {h_reg.rx[5:0], dq_s[1:0]};
								default: h_next.rx = {h_reg.rx[6:0], dq_s[1]};
							endcase
							h_next.rx_bits = h_reg.rx_bits + {1'b0, w};
							if (h_next.rx_bits == 4'h8) begin
								h_next.data = h_next.rx;
								h_next.valid = 1'b1;
								h_next.rx_bits = 4'h0;
							end
						end
						h_next.clocks = (h_reg.clocks == 8'hFF) ? h_reg.clocks
							: h_reg.clocks + 8'h01;
					end else begin
						// falling edge: present next command bits msb first
						h_next.dq_oe = 4'h0;
						if (h_next.clocks < pre_clocks) begin
							if (h_reg.cmd == 3'(flash_read_pkg::CMD_DUAL_IO)
								&& (h_reg.tx[47] ? 1'b1 : h_reg.clocks >= 8'd8)) begin
								h_next.dq_out = {2'b00, h_reg.tx[39:38]};
								h_next.dq_oe = (pre_clocks - h_reg.clocks <= 8'd2)
									? 4'h0 : 4'h3;
								h_next.tx = {h_reg.tx[47:40], h_reg.tx[37:0], 2'b00};
							end else begin
								h_next.dq_out = {3'b000, h_reg.tx[39]};
								h_next.dq_oe = 4'h1;
								h_next.tx = {h_reg.tx[47:40], h_reg.tx[38:0], 1'b0};
							end
						end
						if (stop_i)
							h_next.st = H_END;
					end
				end
			end
			H_END: begin
				h_next.sel_n = 1'b1;
				h_next.dq_oe = 4'h0;
				h_next.st = H_IDLE;
			end
			default: h_next.st = H_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			h_reg.st      <= H_IDLE;
			h_reg.div     <= 8'h00;
			h_reg.sck     <= 1'b0;
			h_reg.sel_n   <= 1'b1;
			h_reg.pause_n <= 1'b1;
			h_reg.cmd     <= 3'h0;
			h_reg.tx      <= 48'h000000000000;
			h_reg.clocks  <= 8'h00;
			h_reg.rx      <= 8'h00;
			h_reg.rx_bits <= 4'h0;
			h_reg.data    <= 8'h00;
			h_reg.valid   <= 1'b0;
			h_reg.dq_out  <= 4'h0;
			h_reg.dq_oe   <= 4'h0;
		end else begin
			h_reg <= h_next;
		end
	end

	assign link.sck        = h_reg.sck;
	assign link.select_n   = h_reg.sel_n;
	assign link.pause_n    = h_reg.pause_n;
	assign link.host_dq_o  = h_reg.dq_out;
	assign link.host_dq_oe = h_reg.dq_oe;
	assign ready_o         = h_reg.st[0];
	assign data_o          = h_reg.data;
	assign data_valid_o    = h_reg.valid;
endmodule
`default_nettype wire

// >>> verification/flash_link_monitor.sv
// link checker for the flash read path
`timescale 1ns/1ps
`default_nettype none
module flash_link_monitor #(
	parameter int HALF_DIV = 2
) (
	input  wire logic       clk_sys_i,
	input  wire logic       reset_n_i,
	input  wire logic       sck,
	input  wire logic       select_n,
	input  wire logic       pause_n,
	input  wire logic [3:0] host_dq_oe,
	input  wire logic [3:0] dev_dq_o,
	input  wire logic [3:0] dev_dq_oe
);
	logic       sck_reg;
	logic [7:0] hold_cnt_reg;

	// ==========================================
	// sck hold counter
	// counts samples since the last link clock change
	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			sck_reg <= 1'b0;
			hold_cnt_reg <= 8'hFF;
		end else begin
			sck_reg <= sck;
			if (sck != sck_reg)
				hold_cnt_reg <= 8'h01;
			else if (hold_cnt_reg != 8'hFF)
				hold_cnt_reg <= hold_cnt_reg + 8'h01;
		end
	end

	// ==========================================
	// link properties
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!reset_n_i);

	sequence s_deselected;
		select_n [*5];
	endsequence

	sequence s_paused;
		(!select_n && !pause_n) [*4];
	endsequence

	a_desel_float: assert property (s_deselected |-> dev_dq_oe == 4'h0)
		else $error("device drives while deselected");
	a_release_float: assert property ($rose(select_n) |-> ##[1:4] (dev_dq_oe == 4'h0))
		else $error("device still drives after deselect");
	a_pause_float: assert property (s_paused |-> dev_dq_oe == 4'h0)
		else $error("device drives while paused");
	a_pause_start_low: assert property ($fell(pause_n) |-> !sck)
		else $error("pause begun with clock high");
	a_pause_end_low: assert property ($rose(pause_n) |-> !sck)
		else $error("pause ended with clock high");
	a_sck_rate_limit: assert property ((sck != sck_reg) && !select_n |-> hold_cnt_reg >= 8'(HALF_DIV))
		else $error("link clock too fast");
	a_data_on_fall: assert property (($changed(dev_dq_o) && dev_dq_oe != 4'h0
		&& $past(dev_dq_oe) != 4'h0) |-> !sck)
		else $error("device data changed with clock high");
	a_lane_pattern: assert property (dev_dq_oe inside {4'h0, 4'h2, 4'h3, 4'hF})
		else $error("device drives an illegal set of lines");
	a_no_contention: assert property ((dev_dq_oe & host_dq_oe) == 4'h0)
		else $error("both ends drive a data line");
	a_idle_clock_low: assert property (select_n |-> !sck)
		else $error("link clock high while deselected");
endmodule
`default_nettype wire

// >>> verification/test_serial_flash_fast_read_path.sv
// self-checking bench for the flash read path
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin n_mismatch++; \
	$display("CHECK FAILED %s exp %h got %h", nm, e, s); end end
module test_serial_flash_fast_read_path;
	localparam int HALF = 6;
	localparam int LIM  = 20000;
	logic        clk_sys_i, reset_n_i, write_in_progress, start, keep_cont, skip_op, stop, pause;
	logic        ready, dvalid, busy, cont_mode;
	logic [2:0]  cmd;
	logic [23:0] addr;
	logic [7:0]  mem_addr, mem_data, data;
	int          n_mismatch, n_tests;

	// ==========================================
	// memory contents: nibble swap with a fixed mask
	function automatic logic [7:0] pat(input logic [7:0] a);
		return {a[3:0], a[7:4]} ^ 8'h5A;
	endfunction
	assign mem_data = pat(mem_addr);

	flash_link_if lnk();
	flash_read_device #(.ARRAY_ADDR_BITS(8)) i_flash_read_device (.clk_sys_i(clk_sys_i),
		.reset_n_i(reset_n_i), .link(lnk), .write_in_progress_i(write_in_progress), .mem_addr_o(mem_addr),
		.mem_data_i(mem_data), .busy_o(busy), .continuous_read_mode_o(cont_mode));
	flash_read_host #(.HALF_DIV(HALF)) i_flash_read_host (.clk_sys_i(clk_sys_i),
		.reset_n_i(reset_n_i), .link(lnk), .start_i(start), .cmd_i(cmd), .addr_i(addr),
		.keep_cont_i(keep_cont), .skip_opcode_i(skip_op), .stop_i(stop), .pause_i(pause),
		.ready_o(ready), .data_o(data), .data_valid_o(dvalid));
	flash_link_monitor #(.HALF_DIV(HALF)) i_flash_link_monitor (.clk_sys_i(clk_sys_i),
		.reset_n_i(reset_n_i), .sck(lnk.sck), .select_n(lnk.select_n), .pause_n(lnk.pause_n),
		.host_dq_oe(lnk.host_dq_oe), .dev_dq_o(lnk.dev_dq_o), .dev_dq_oe(lnk.dev_dq_oe));

	// ==========================================
	// verdict and hang handling
	task automatic end_of_test;
		if (n_mismatch == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic give_up;
		n_mismatch++;
		end_of_test();
	endtask

	// ==========================================
	// transfer helpers
	task automatic issue(input logic [2:0] c, input logic [23:0] a, input logic kc,
		input logic sk);
		@(posedge clk_sys_i);
		cmd <= c;
		addr <= a;
		keep_cont <= kc;
		skip_op <= sk;
		start <= 1'b1;
		@(posedge clk_sys_i) start <= 1'b0;
	endtask

	// hold stop until the host is idle again
	task automatic finish_xfer;
		int t;
		t = 0;
		@(posedge clk_sys_i) stop <= 1'b1;
		do begin
			@(negedge clk_sys_i);
			t++;
		end while (ready !== 1'b1 && t < LIM);
		if (t >= LIM) give_up();
		@(posedge clk_sys_i) stop <= 1'b0;
	endtask

	// pause for a while and see the device float
	task automatic pause_gap;
		@(posedge clk_sys_i) pause <= 1'b1;
		repeat (40) @(posedge clk_sys_i);
		`CHK("paused drive", 4'h0, lnk.dev_dq_oe)
		pause <= 1'b0;
	endtask

	// read n bytes from a, pausing after byte pz when pz is nonzero
	task automatic read_run(input logic [2:0] c, input logic [23:0] a, input int n,
		input logic kc, input logic sk, input int pz);
		int k, t;
		k = 0;
		t = 0;
		issue(c, a, kc, sk);
		while (k < n && t < LIM) begin
			@(negedge clk_sys_i);
			t++;
			if (dvalid === 1'b1) begin
				`CHK("read byte", pat(a[7:0] + 8'(k)), data)
				k++;
				if (k == pz) pause_gap();
			end
		end
		if (t >= LIM) give_up();
		finish_xfer();
	endtask

	// ==========================================
	// scenarios
	// every command from the byte below the top so the address wraps
	task automatic t_each_cmd;
		for (int c = 0; c < 4; c++)
			read_run(3'(c), 24'hA5A5FE, 3, 1'b0, 1'b0, 0);
		`CHK("mode after FF", 1'b0, cont_mode)
	endtask

	// pause mid byte stream, progress kept
	task automatic t_pause;
		read_run(3'h2, 24'h000040, 4, 1'b0, 1'b0, 2);
		read_run(3'h0, 24'h000051, 3, 1'b0, 1'b0, 1);
	endtask

	// enter, reuse and leave continuous read
	task automatic t_cont_mode;
		read_run(3'h1, 24'h000010, 2, 1'b1, 1'b0, 0);
		`CHK("mode entered", 1'b1, cont_mode)
		read_run(3'h1, 24'h000080, 2, 1'b1, 1'b1, 1);
		`CHK("mode kept", 1'b1, cont_mode)
		read_run(3'h1, 24'h0000C0, 2, 1'b0, 1'b1, 0);
		`CHK("mode left", 1'b0, cont_mode)
		read_run(3'h3, 24'h000020, 2, 1'b0, 1'b0, 0);
	endtask

	// read refused while a write runs, then accepted
	task automatic t_write_busy;
		int hits;
		hits = 0;
		@(posedge clk_sys_i) write_in_progress <= 1'b1;
		issue(3'h0, 24'h000030, 1'b0, 1'b0);
		repeat (800) begin
			@(negedge clk_sys_i);
			if ((dvalid === 1'b1 && data !== 8'hFF) || lnk.dev_dq_oe !== 4'h0) hits++;
		end
		`CHK("activity while writing", 0, hits)
		`CHK("busy while refused", 1'b1, busy)
		finish_xfer();
		@(posedge clk_sys_i) write_in_progress <= 1'b0;
		repeat (4) @(negedge clk_sys_i);
		`CHK("idle after deselect", 1'b0, busy)
		read_run(3'h0, 24'h000030, 2, 1'b0, 1'b0, 0);
	endtask

	initial begin
		clk_sys_i = 1'b0;
		forever #2.5 clk_sys_i = ~clk_sys_i;
	end

	initial begin
		n_mismatch = 0;
		n_tests = 0;
		reset_n_i = 1'b0;
		{write_in_progress, start, keep_cont, skip_op, stop, pause} = 6'h00;
		cmd = 3'h0;
		addr = 24'h000000;
		repeat (16) @(posedge clk_sys_i);
		reset_n_i <= 1'b1;
		t_each_cmd();
		t_pause();
		t_cont_mode();
		t_write_busy();
		end_of_test();
	end
endmodule
`default_nettype wire
